/* fuhc_chk_sva.sv */
/*
  Checker for the hazard checker top: blocked cycles and kinds at the ports.
  Assumes one clock and is attached to fuhc_top by the bind at the foot.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fuhc_map.vh"
module fuhc_chk (
  input wire CORE_CLK_I,
  input wire RESET_I,
  input wire ISSUE_VALID_I,
  input wire [`FUHC_UNIT_W-1:0] ISSUE_UNIT_I,
  input wire [`FUHC_CLS_W-1:0] ISSUE_CLASS_I,
  input wire ISSUE_CROSS_I,
  input wire CAND_VALID_I,
  input wire [`FUHC_UNIT_W-1:0] CAND_UNIT_I,
  input wire [`FUHC_CLS_W-1:0] CAND_CLASS_I,
  input wire CAND_CROSS_I,
  input wire CAND_BLOCKED_O,
  input wire [`FUHC_KIND_W-1:0] CAND_KIND_O
);
  // ----------------------------------------
  // Issued and candidate classes
  // ----------------------------------------
  wire m = ISSUE_VALID_I && ISSUE_UNIT_I == `FUHC_UNIT_MUL;
  wire big = m && ISSUE_CLASS_I >= `FUHC_CLS_INT32_MUL && ISSUE_CLASS_I <= `FUHC_CLS_DP_MUL;
  wire i32 = m && ISSUE_CLASS_I == `FUHC_CLS_INT32_MUL;
  wire wide = big && !i32;
  wire cm = CAND_VALID_I && CAND_UNIT_I == `FUHC_UNIT_MUL;
  wire cm16 = cm && CAND_CLASS_I == `FUHC_CLS_MUL16;
  wire lg4 = ISSUE_VALID_I && ISSUE_UNIT_I == `FUHC_UNIT_LOG && ISSUE_CLASS_I == `FUHC_CLS_FOUR;
  wire dp2 = ISSUE_VALID_I && ISSUE_UNIT_I == `FUHC_UNIT_BS && ISSUE_CLASS_I == `FUHC_CLS_DP2;
  wire cbs = CAND_VALID_I && CAND_UNIT_I == `FUHC_UNIT_BS;
  wire cbs_wr = cbs && (CAND_CLASS_I == `FUHC_CLS_SINGLE || CAND_CLASS_I == `FUHC_CLS_DP2);
  wire clg = CAND_VALID_I && CAND_UNIT_I == `FUHC_UNIT_LOG;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  idle_zero_a: assert property (!CAND_VALID_I |-> CAND_KIND_O == 3'h0 && !CAND_BLOCKED_O)
    else $error("kind set without candidate");
  blocked_kind_a: assert property (CAND_BLOCKED_O == (CAND_KIND_O != 3'h0))
    else $error("blocked flag disagrees with kind");
  dp2_write_a: assert property (cbs_wr && $past(dp2) |-> CAND_KIND_O[1])
    else $error("write hazard after two-cycle op missed");
  four_write_a: assert property (cm16 && $past(m && ISSUE_CLASS_I == `FUHC_CLS_FOUR, 2) |-> CAND_KIND_O[1])
    else $error("multiply write hazard missed");
  read_blk_a: assert property (cm && ($past(big) || $past(big, 2) || $past(big, 3)) |-> CAND_KIND_O[0])
    else $error("read block missed");
  mul16_late_a: assert property (cm16 && ($past(i32, 7) || $past(wide, 7) || $past(wide, 8)) |-> CAND_KIND_O[1])
    else $error("late multiply write hazard missed");
  four_res_a: assert property (cm && CAND_CLASS_I == `FUHC_CLS_FOUR && $past(big, 4) |-> CAND_KIND_O[2])
    else $error("resource block missed");
  log_write_a: assert property (clg && CAND_CLASS_I == `FUHC_CLS_SINGLE && $past(lg4, 3) |-> CAND_KIND_O[1])
    else $error("logic write hazard missed");
  cross_hold_a: assert property (clg && CAND_CROSS_I && $past(i32 && ISSUE_CROSS_I, 2) |-> CAND_KIND_O[2])
    else $error("cross path hold missed");
  cross_now_a: assert property (clg && CAND_CROSS_I && CAND_CLASS_I != `FUHC_CLS_BRANCH && big && ISSUE_CROSS_I |-> CAND_KIND_O[2])
    else $error("issue cycle cross path hold missed");
endmodule // fuhc_chk
bind fuhc_top fuhc_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .ISSUE_VALID_I(ISSUE_VALID_I),
  .ISSUE_UNIT_I(ISSUE_UNIT_I), .ISSUE_CLASS_I(ISSUE_CLASS_I), .ISSUE_CROSS_I(ISSUE_CROSS_I),
  .CAND_VALID_I(CAND_VALID_I), .CAND_UNIT_I(CAND_UNIT_I), .CAND_CLASS_I(CAND_CLASS_I),
  .CAND_CROSS_I(CAND_CROSS_I), .CAND_BLOCKED_O(CAND_BLOCKED_O), .CAND_KIND_O(CAND_KIND_O));
`default_nettype wire

/* fuhc_map.vh */
/*
  Constants for the functional unit hazard checker: instruction class codes,
  unit codes, conflict kind codes and table depth.
  Assumes it is included by bare name from the design files.
*/
`ifndef FUHC_MAP_VH
`define FUHC_MAP_VH

// ----------------------------------------
// Instruction classes
// ----------------------------------------
`define FUHC_CLS_W 4
`define FUHC_CLS_SINGLE 4'h0
`define FUHC_CLS_DP_CMP 4'h1
`define FUHC_CLS_DP2 4'h2
`define FUHC_CLS_BRANCH 4'h3
`define FUHC_CLS_MUL16 4'h4
`define FUHC_CLS_FOUR 4'h5
`define FUHC_CLS_INT32_MUL 4'h6
`define FUHC_CLS_INT32_WIDE 4'h7
`define FUHC_CLS_DP_MUL 4'h8
`define FUHC_CLS_LOAD 4'h9
`define FUHC_CLS_STORE 4'hA
`define FUHC_CLS_INT_TO_DP 4'hB
`define FUHC_CLS_DP_ADDSUB 4'hC

// ----------------------------------------
// Units
// ----------------------------------------
`define FUHC_UNIT_W 2
`define FUHC_UNIT_BS 2'h0
`define FUHC_UNIT_MUL 2'h1
`define FUHC_UNIT_LOG 2'h2
`define FUHC_UNIT_OTHER 2'h3

// ----------------------------------------
// Conflict kinds, one bit each
// ----------------------------------------
`define FUHC_KIND_W 3
`define FUHC_KIND_READ 3'h1
`define FUHC_KIND_WRITE 3'h2
`define FUHC_KIND_RES 3'h4

// Cycles ahead that the record covers (cycle 2 .. 11 of issued op)
`define FUHC_DEPTH 10

`endif

/* fuhc_slot_line.v */
/*
  One delay line of conflict kinds: a per-cycle record of blocked cycles.
  Assumes the caller merges a new pattern at issue; slot 0 is the next cycle.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fuhc_map.vh"

module fuhc_slot_line #(
  parameter DEPTH = `FUHC_DEPTH
) (
  input wire clk_i,
  input wire rst_i,
  input wire [DEPTH*`FUHC_KIND_W-1:0] load_i,
  output wire [DEPTH*`FUHC_KIND_W-1:0] line_o
);
  reg [DEPTH*`FUHC_KIND_W-1:0] line;
  wire [DEPTH*`FUHC_KIND_W-1:0] shifted;

  assign shifted = {{`FUHC_KIND_W{1'b0}}, line[DEPTH*`FUHC_KIND_W-1:`FUHC_KIND_W]};
  assign line_o = line;

  // ----------------------------------------
  // Shift toward slot 0, merge new blocking
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      line <= {DEPTH*`FUHC_KIND_W{1'b0}};
    end else begin
      line <= shifted | load_i;
    end
  end
endmodule // fuhc_slot_line
`default_nettype wire

/* fuhc_top.v */
/*
  Functional unit hazard checker for one side of a VLIW datapath.
  Tracks instructions already issued on the branch/shift, multiplier and logic
  units and flags a candidate whose first execute phase lands on a blocked
  cycle, same unit or same side over the shared cross path.
  Assumes issue and candidate inputs come from logic on CORE_CLK_I.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fuhc_map.vh"

// Behaviour
// RULE_01 - Two-cycle DP blocks same-unit write next cycle
// RULE_02 - Branch imposes no blocking cycles
// RULE_03 - Only register branch reads a general register
// RULE_04 - 16x16 multiply blocks nothing
// RULE_05 - Four-cycle multiply blocks 16x16 at cycle three
// RULE_06 - Int32 multiply read-blocks cycles two to four
// RULE_07 - Int32 multiply later resource and write blocks
// RULE_08 - Wide int multiply read and write blocks
// RULE_09 - DP multiply read, resource, write blocks
// RULE_10 - Four-cycle op blocked cycles five to seven
// RULE_11 - Logic single-cycle op blocks nothing
// RULE_12 - Logic four-cycle op write-blocks single at four
// RULE_13 - Keep per-cycle records, flag blocked candidates
// RULE_14 - Int32 cross read holds cross path four cycles
module fuhc_top (
  input wire CORE_CLK_I,
  input wire RESET_I,
  input wire ISSUE_VALID_I,
  input wire [`FUHC_UNIT_W-1:0] ISSUE_UNIT_I,
  input wire [`FUHC_CLS_W-1:0] ISSUE_CLASS_I,
  input wire ISSUE_CROSS_I,
  input wire ISSUE_REG_BRANCH_I,
  input wire CAND_VALID_I,
  input wire [`FUHC_UNIT_W-1:0] CAND_UNIT_I,
  input wire [`FUHC_CLS_W-1:0] CAND_CLASS_I,
  input wire CAND_CROSS_I,
  input wire CAND_REG_BRANCH_I,
  output wire CAND_BLOCKED_O,
  output wire [`FUHC_KIND_W-1:0] CAND_KIND_O
);
  localparam D = `FUHC_DEPTH;
  localparam KW = `FUHC_KIND_W;
  localparam NCLS = 16;
  localparam LW = D*KW;

  // ----------------------------------------
  // Per-cycle records: three units by classes, plus cross path
  // ----------------------------------------
  reg [LW-1:0] bs_load [0:NCLS-1];
  reg [LW-1:0] mu_load [0:NCLS-1];
  reg [LW-1:0] lg_load [0:NCLS-1];
  reg [LW-1:0] xp_load;
  wire [LW-1:0] bs_line [0:NCLS-1];
  wire [LW-1:0] mu_line [0:NCLS-1];
  wire [LW-1:0] lg_line [0:NCLS-1];
  wire [LW-1:0] xp_line;
  wire reads_reg;
  integer c;

  // Any non-branch op, or a register-sourced branch, counts as a register reader
  assign reads_reg = (ISSUE_CLASS_I != `FUHC_CLS_BRANCH) || ISSUE_REG_BRANCH_I; // RULE_03

  // OR one conflict kind into the slot of op cycle cyc (cycle 2 is slot 0)
  function [LW-1:0] put;
    input [LW-1:0] base;
    input integer cyc;
    input [KW-1:0] kind;
    begin
      put = base;
      put[(cyc-2)*KW +: KW] = base[(cyc-2)*KW +: KW] | kind;
    end
  endfunction

  // ----------------------------------------
  // Blocking patterns merged at issue
  // ----------------------------------------
  // Each unit record is indexed by the class of the candidate it will block
  always @* begin
    for (c = 0; c < NCLS; c = c + 1) begin
      bs_load[c] = {LW{1'b0}};
      mu_load[c] = {LW{1'b0}};
      lg_load[c] = {LW{1'b0}};
    end
    xp_load = {LW{1'b0}};
    if (ISSUE_VALID_I) begin
      case (ISSUE_UNIT_I)
        `FUHC_UNIT_BS: begin
          // Branch and single ops leave the patterns clear
          if (ISSUE_CLASS_I == `FUHC_CLS_DP2) begin
            bs_load[`FUHC_CLS_SINGLE] = put(bs_load[`FUHC_CLS_SINGLE], 2, `FUHC_KIND_WRITE); // RULE_01
            bs_load[`FUHC_CLS_DP2] = put(bs_load[`FUHC_CLS_DP2], 2, `FUHC_KIND_WRITE); // RULE_01
          end
        end
        `FUHC_UNIT_MUL: begin
          case (ISSUE_CLASS_I)
            `FUHC_CLS_MUL16: begin
              mu_load[0] = {LW{1'b0}}; // RULE_04
            end
            `FUHC_CLS_FOUR: begin
              mu_load[`FUHC_CLS_MUL16] = put(mu_load[`FUHC_CLS_MUL16], 3, `FUHC_KIND_WRITE); // RULE_05
            end
            `FUHC_CLS_INT32_MUL, `FUHC_CLS_INT32_WIDE, `FUHC_CLS_DP_MUL: begin
              for (c = 0; c < NCLS; c = c + 1) begin
                mu_load[c] = put(mu_load[c], 2, `FUHC_KIND_READ); // RULE_06
                mu_load[c] = put(mu_load[c], 3, `FUHC_KIND_READ); // RULE_06
                mu_load[c] = put(mu_load[c], 4, `FUHC_KIND_READ); // RULE_06
              end
              // Operand reads of cycles 2 to 4 also tie up the shared cross path decode
              xp_load = put(xp_load, 2, `FUHC_KIND_READ); // RULE_08
              xp_load = put(xp_load, 3, `FUHC_KIND_READ); // RULE_08
              xp_load = put(xp_load, 4, `FUHC_KIND_READ); // RULE_08
              // Four-cycle ops collide with the long op's resources and write port
              mu_load[`FUHC_CLS_FOUR] = put(mu_load[`FUHC_CLS_FOUR], 5, `FUHC_KIND_RES); // RULE_10
              mu_load[`FUHC_CLS_FOUR] = put(mu_load[`FUHC_CLS_FOUR], 6, `FUHC_KIND_WRITE); // RULE_10
              if (ISSUE_CLASS_I == `FUHC_CLS_INT32_MUL) begin
                mu_load[`FUHC_CLS_FOUR] = put(mu_load[`FUHC_CLS_FOUR], 7, `FUHC_KIND_RES); // RULE_07
                mu_load[`FUHC_CLS_MUL16] = put(mu_load[`FUHC_CLS_MUL16], 8, `FUHC_KIND_WRITE); // RULE_07
              end else begin
                mu_load[`FUHC_CLS_FOUR] = put(mu_load[`FUHC_CLS_FOUR], 7, `FUHC_KIND_WRITE); // RULE_10
                mu_load[`FUHC_CLS_MUL16] = put(mu_load[`FUHC_CLS_MUL16], 8, `FUHC_KIND_WRITE); // RULE_08
                mu_load[`FUHC_CLS_MUL16] = put(mu_load[`FUHC_CLS_MUL16], 9, `FUHC_KIND_WRITE); // RULE_08
              end
              for (c = 5; c <= 7; c = c + 1) begin
                if (ISSUE_CLASS_I == `FUHC_CLS_DP_MUL) begin
                  mu_load[`FUHC_CLS_INT32_MUL] = put(mu_load[`FUHC_CLS_INT32_MUL], c, `FUHC_KIND_RES); // RULE_09
                  mu_load[`FUHC_CLS_INT32_WIDE] = put(mu_load[`FUHC_CLS_INT32_WIDE], c, `FUHC_KIND_RES); // RULE_09
                end else begin
                  mu_load[`FUHC_CLS_DP_MUL] = put(mu_load[`FUHC_CLS_DP_MUL], c, `FUHC_KIND_RES); // RULE_07
                end
              end
              // Cross-sourced int32 multiply holds the cross path i..i+3
              if (ISSUE_CROSS_I && reads_reg) begin
                xp_load = put(xp_load, 2, `FUHC_KIND_RES); // RULE_14
                xp_load = put(xp_load, 3, `FUHC_KIND_RES); // RULE_14
                xp_load = put(xp_load, 4, `FUHC_KIND_RES); // RULE_14
              end
            end
            default: begin
              mu_load[0] = {LW{1'b0}};
            end
          endcase
        end
        `FUHC_UNIT_LOG: begin
          // Single-cycle logic op completes within its own cycle
          if (ISSUE_CLASS_I == `FUHC_CLS_FOUR) begin
            lg_load[`FUHC_CLS_SINGLE] = put(lg_load[`FUHC_CLS_SINGLE], 4, `FUHC_KIND_WRITE); // RULE_12
          end else begin
            lg_load[0] = {LW{1'b0}}; // RULE_11
          end
        end
        default: begin
          xp_load = {LW{1'b0}};
        end
      endcase
    end
  end

  // ----------------------------------------
  // Records as delay lines
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCLS; g = g + 1) begin : g_cls
      fuhc_slot_line #(.DEPTH(D)) u_bs (.clk_i(CORE_CLK_I), .rst_i(RESET_I),
        .load_i(bs_load[g]), .line_o(bs_line[g])); // RULE_13
      fuhc_slot_line #(.DEPTH(D)) u_mu (.clk_i(CORE_CLK_I), .rst_i(RESET_I),
        .load_i(mu_load[g]), .line_o(mu_line[g])); // RULE_13
      fuhc_slot_line #(.DEPTH(D)) u_lg (.clk_i(CORE_CLK_I), .rst_i(RESET_I),
        .load_i(lg_load[g]), .line_o(lg_line[g])); // RULE_13
    end
  endgenerate

  fuhc_slot_line #(.DEPTH(D)) u_xp (.clk_i(CORE_CLK_I), .rst_i(RESET_I),
    .load_i(xp_load), .line_o(xp_line)); // RULE_13

  // ----------------------------------------
  // Candidate check against slot 0 (the current cycle)
  // ----------------------------------------
  reg [KW-1:0] kind;
  wire cand_reads;
  wire cand_cross;
  wire issue_long_mul;
  wire cross_now;

  assign cand_reads = (CAND_CLASS_I != `FUHC_CLS_BRANCH) || CAND_REG_BRANCH_I; // RULE_02
  // Multiplier candidates are covered by their own same-unit table
  assign cand_cross = (CAND_UNIT_I != `FUHC_UNIT_MUL) && CAND_CROSS_I && cand_reads; // RULE_03

  // ----------------------------------------
  // Issue-cycle cross path hold
  // ----------------------------------------
  // The record starts at the cycle after issue, so the issue cycle itself
  // is taken straight from the issue inputs
  assign issue_long_mul = ISSUE_VALID_I && (ISSUE_UNIT_I == `FUHC_UNIT_MUL) &&
    ((ISSUE_CLASS_I == `FUHC_CLS_INT32_MUL) || (ISSUE_CLASS_I == `FUHC_CLS_INT32_WIDE) ||
    (ISSUE_CLASS_I == `FUHC_CLS_DP_MUL));
  assign cross_now = issue_long_mul && ISSUE_CROSS_I && reads_reg; // RULE_14

  always @* begin
    kind = {KW{1'b0}};
    if (CAND_VALID_I) begin
      case (CAND_UNIT_I)
        `FUHC_UNIT_BS: kind = bs_line[CAND_CLASS_I][KW-1:0];
        `FUHC_UNIT_MUL: kind = mu_line[CAND_CLASS_I][KW-1:0];
        `FUHC_UNIT_LOG: kind = lg_line[CAND_CLASS_I][KW-1:0];
        default: kind = {KW{1'b0}};
      endcase
      if (cand_cross) begin
        kind = kind | xp_line[KW-1:0]; // RULE_13
      end
      // Cross path users also meet a long multiply issued this very cycle
      if (cand_cross && cross_now) begin
        kind = kind | `FUHC_KIND_RES; // RULE_14
      end
    end
  end

  assign CAND_KIND_O = kind;
  assign CAND_BLOCKED_O = |kind; // RULE_13
endmodule // fuhc_top
`default_nettype wire

/* tb_top.sv */
/*
  Self-checking bench for the hazard checker: issue, wait, probe a candidate.
  Assumes the checker is bound in by its own file.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fuhc_map.vh"
module tb_top;
  localparam [1:0] BS = `FUHC_UNIT_BS, MU = `FUHC_UNIT_MUL, LG = `FUHC_UNIT_LOG;
  localparam [3:0] SG = `FUHC_CLS_SINGLE, D2 = `FUHC_CLS_DP2, BR = `FUHC_CLS_BRANCH, M16 = `FUHC_CLS_MUL16;
  localparam [3:0] FR = `FUHC_CLS_FOUR, I32 = `FUHC_CLS_INT32_MUL, IW = `FUHC_CLS_INT32_WIDE, DM = `FUHC_CLS_DP_MUL;
  reg clk = 1'b0, rst = 1'b1, iv = 1'b0, ix = 1'b0, irb = 1'b0, cv = 1'b0, cx = 1'b0, crb = 1'b0;
  reg [1:0] iu = BS, cu = BS;
  reg [3:0] ic = SG, cc = SG;
  wire blk;
  wire [2:0] kind;
  integer err_count = 0, n_checks = 0, cycles = 0;
  always #5 clk = ~clk;
  fuhc_top dut (.CORE_CLK_I(clk), .RESET_I(rst), .ISSUE_VALID_I(iv), .ISSUE_UNIT_I(iu), .ISSUE_CLASS_I(ic),
    .ISSUE_CROSS_I(ix), .ISSUE_REG_BRANCH_I(irb), .CAND_VALID_I(cv), .CAND_UNIT_I(cu), .CAND_CLASS_I(cc),
    .CAND_CROSS_I(cx), .CAND_REG_BRANCH_I(crb), .CAND_BLOCKED_O(blk), .CAND_KIND_O(kind));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      end_sim;
    end
  end
  task chk(input [2:0] e);
    begin
      n_checks = n_checks + 1;
      if (kind !== e || blk !== (e != 3'h0)) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: kind %h expected %h", $time, kind, e);
      end
    end
  endtask
  // Issue one op, then a candidate in its cycle k, then let the record drain
  task probe(input [1:0] u, input [3:0] c, input x, input integer k, input [1:0] v, input [3:0] d, input y,
    input [2:0] e);
    begin
      @(posedge clk);
      #1 iv = 1'b1;
      iu = u;
      ic = c;
      ix = x;
      repeat (k - 1) begin
        @(posedge clk);
        #1 iv = 1'b0;
      end
      cv = 1'b1;
      cu = v;
      cc = d;
      cx = y;
      #1 chk(e);
      @(posedge clk);
      #1 iv = 1'b0;
      cv = 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_bs;
    begin
      probe(BS, D2, 1'b0, 2, BS, SG, 1'b0, 3'h2);
      probe(BS, D2, 1'b0, 2, BS, D2, 1'b0, 3'h2);
      probe(BS, D2, 1'b0, 3, BS, SG, 1'b0, 3'h0);
      probe(BS, BR, 1'b1, 2, BS, SG, 1'b1, 3'h0);
      $display("branch shift unit test done");
    end
  endtask
  task t_mul;
    begin
      probe(MU, M16, 1'b0, 2, MU, M16, 1'b0, 3'h0);
      probe(MU, FR, 1'b0, 3, MU, M16, 1'b0, 3'h2);
      probe(MU, FR, 1'b0, 4, MU, M16, 1'b0, 3'h0);
      $display("multiplier short op test done");
    end
  endtask
  task t_i32;
    begin
      probe(MU, I32, 1'b0, 2, MU, M16, 1'b0, 3'h1);
      probe(MU, I32, 1'b0, 4, MU, SG, 1'b0, 3'h1);
      probe(MU, I32, 1'b0, 5, MU, M16, 1'b0, 3'h0);
      probe(MU, I32, 1'b0, 3, LG, SG, 1'b1, 3'h1);
      probe(MU, I32, 1'b0, 3, LG, SG, 1'b0, 3'h0);
      probe(MU, I32, 1'b0, 5, MU, FR, 1'b0, 3'h4);
      probe(MU, I32, 1'b0, 6, MU, FR, 1'b0, 3'h2);
      probe(MU, I32, 1'b0, 7, MU, FR, 1'b0, 3'h4);
      probe(MU, I32, 1'b0, 8, MU, M16, 1'b0, 3'h2);
      probe(MU, I32, 1'b0, 6, MU, DM, 1'b0, 3'h4);
      probe(MU, I32, 1'b1, 3, LG, SG, 1'b1, 3'h5);
      probe(MU, I32, 1'b1, 5, LG, SG, 1'b1, 3'h0);
      probe(MU, I32, 1'b1, 1, LG, SG, 1'b1, 3'h4);
      probe(MU, DM, 1'b1, 1, BS, SG, 1'b1, 3'h4);
      probe(MU, I32, 1'b1, 2, BS, BR, 1'b1, 3'h0);
      #1 crb = 1'b1;
      probe(MU, I32, 1'b1, 2, BS, BR, 1'b1, 3'h5);
      #1 crb = 1'b0;
      $display("int32 multiply test done");
    end
  endtask
  task t_wide;
    begin
      probe(MU, IW, 1'b0, 8, MU, M16, 1'b0, 3'h2);
      probe(MU, IW, 1'b0, 9, MU, M16, 1'b0, 3'h2);
      probe(MU, IW, 1'b0, 10, MU, M16, 1'b0, 3'h0);
      probe(MU, IW, 1'b0, 5, MU, FR, 1'b0, 3'h4);
      probe(MU, DM, 1'b0, 7, MU, FR, 1'b0, 3'h2);
      probe(MU, DM, 1'b0, 4, MU, M16, 1'b0, 3'h1);
      probe(MU, DM, 1'b0, 5, MU, I32, 1'b0, 3'h4);
      probe(MU, DM, 1'b0, 7, MU, IW, 1'b0, 3'h4);
      probe(MU, DM, 1'b0, 9, MU, M16, 1'b0, 3'h2);
      $display("wide multiply test done");
    end
  endtask
  task t_log;
    begin
      probe(LG, SG, 1'b1, 2, LG, SG, 1'b1, 3'h0);
      probe(LG, FR, 1'b0, 4, LG, SG, 1'b0, 3'h2);
      probe(LG, FR, 1'b0, 5, LG, SG, 1'b0, 3'h0);
      $display("logic unit test done");
    end
  endtask
  task t_rst;
    begin
      @(posedge clk);
      #1 iv = 1'b1;
      iu = MU;
      ic = I32;
      ix = 1'b0;
      @(posedge clk);
      #1 iv = 1'b0;
      rst = 1'b1;
      @(posedge clk);
      #1 rst = 1'b0;
      cv = 1'b1;
      cu = LG;
      cc = SG;
      cx = 1'b1;
      #1 chk(3'h0);
      @(posedge clk);
      #1 chk(3'h0);
      @(posedge clk);
      #1 cv = 1'b0;
      $display("mid-run reset test done");
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_bs;
    t_mul;
    t_i32;
    t_wide;
    t_log;
    t_rst;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
